// ---- logic/scb_pkg.sv ----
package scb_pkg;
  // Register byte addresses
  localparam logic [31:0] OFF_FRAC_DENOM  = 32'h400480d0;
  localparam logic [31:0] OFF_FRAC_NUM    = 32'h400480d4;
  localparam logic [31:0] OFF_FRAC_SRC    = 32'h400480d8;
  localparam logic [31:0] OFF_CO_SRC      = 32'h400480f0;
  localparam logic [31:0] OFF_CO_DIV      = 32'h400480f4;
  localparam logic [31:0] OFF_PIN_CAPTURE = 32'h40048100;
  localparam logic [31:0] OFF_BOD_CTRL    = 32'h40048150;
  localparam logic [31:0] OFF_TICK_CAL    = 32'h40048154;
  localparam logic [31:0] OFF_IRQ_LAT     = 32'h40048170;
  localparam logic [31:0] OFF_NMI_SRC     = 32'h40048174;
  localparam logic [31:0] OFF_IRQ_STATUS  = 32'h400481f0;
  localparam logic [31:0] OFF_IRQ_MASK    = 32'h400481f4;
  // Field positions
  localparam int BOD_RST_LEV_LSB = 0;
  localparam int BOD_IRQ_LEV_LSB = 2;
  localparam int BOD_RST_EN_BIT  = 4;
  localparam int NMI_EN_BIT      = 31;
  localparam int IRQ_BOD_BIT     = 0;
  localparam int IRQ_BODRST_BIT  = 1;
  // Valid pins of the power-on capture
  localparam logic [31:0] PIN_VALID_MASK = 32'h7fffffbf;
  // Encodings
  localparam logic [7:0] FRAC_DENOM_ONLY = 8'hff;
  localparam logic [1:0] FRAC_SRC_RSVD   = 2'h2;
  localparam logic [1:0] FRAC_SRC_NONE   = 2'h3;
  localparam logic [2:0] CO_SRC_NONE     = 3'h7;
  localparam logic [1:0] BOD_IRQ_RSVD    = 2'h0;
  // Reset values
  localparam logic [7:0]  RST_FRAC_NUM   = 8'h00;
  localparam logic [7:0]  RST_FRAC_DENOM = 8'h00;
  localparam logic [1:0]  RST_FRAC_SRC   = 2'h0;
  localparam logic [2:0]  RST_CO_SRC     = 3'h0;
  localparam logic [7:0]  RST_CO_DIV     = 8'h00;
  localparam logic [1:0]  RST_BOD_LEV    = 2'h0;
  localparam logic        RST_BOD_RST_EN = 1'b1;
  localparam logic [25:0] RST_TICK_CAL   = 26'h0000000;
  localparam logic [7:0]  RST_IRQ_LAT    = 8'h10;
  localparam logic [4:0]  RST_NMI_NUM    = 5'h00;
  // Cycles after reset release before the synchronised pins are captured
  localparam logic [1:0]  CAPTURE_DELAY  = 2'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scb_bus_t;

  typedef struct packed {
    logic [7:0] numerator;
    logic [1:0] src;
    logic       denomOk;
  } scb_frac_t;

  typedef struct packed {
    logic [2:0] src;
    logic [7:0] div;
    logic       active;
  } scb_clock_output_pin_t;

  typedef struct packed {
    logic [1:0] rstLevel;
    logic [1:0] irqLevel;
    logic       rstEnable;
  } scb_bod_t;

  typedef enum logic [2:0] {
    LAT_IDLE  = 3'b001,
    LAT_WAIT  = 3'b010,
    LAT_GRANT = 3'b100
  } scb_lat_state_t;
endpackage

// ---- logic/scb_sysconfig_regs.sv ----
// Behaviour
// - Numerator register holds 8-bit fractional numerator, used as is, reset zero.
// - Output is source over one plus numerator/256; only denominator code 0xFF valid.
// - Fractional source: 0 oscillator, 1 main clock, 2 reserved, 3 none; reset 0.
// - Clock output source: 0,1,3,4 sources, 7 none, others reserved; reset 0.
// - Clock output divider: zero disables, N from 1 to 255 divides by N.
// - Read-only register captures each port pin level once after power-on reset; pins 6 and 31 are masked and read zero.
// - Brown-out interrupt level codes 1 to 3 select levels; code 0 reserved.
// - Brown-out reset level field bits 1:0, code 0 means level 0.
// - Brown-out reset enable bit 4, set out of reset.
// - Brown-out interrupt, and enabled brown-out reset, request wake-up from sleep.
// - 26-bit calibration value drives the tick timer calibration view, reset zero.
// - 8-bit minimum interrupt latency field, reset 0x10.
// - Interrupt service waits at least the latency count before being granted.
// - Selected request number drives the non-maskable input only while bit 31 set.
// - Selected request raises both non-maskable and normal interrupt together.
//
// Design decision made here: the plain strobed port.
module scb_sysconfig_regs (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // Register port
  input  wire scb_pkg::scb_bus_t   busReq,
  output logic [31:0]              busRdata,
  // Pins and brown-out comparators, asynchronous
  input  wire logic [31:0]         portPinLevels,
  input  wire logic                brownoutIrqCross,
  input  wire logic                brownoutRstCross,
  // Peripheral requests on the core clock
  input  wire logic [31:0]         periphIrq,
  input  wire logic                irqPending,
  // Configuration towards the clock tree and core
  output scb_pkg::scb_frac_t       fracCfg,
  output scb_pkg::scb_clock_output_pin_t     clkOutCfg,
  output scb_pkg::scb_bod_t        bodCfg,
  output logic [25:0]              tickCalibration,
  output logic [7:0]               interrupt_latency,
  // Interrupt and wake-up outputs
  output logic                     irqServiceGrant,
  output logic                     nmiRequest,
  output logic [31:0]              normalIrq,
  output logic                     brownoutIrq,
  output logic                     brownoutResetReq,
  output logic                     wakeRequest,
  output logic                     intr
);

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic clkOutOn(input logic [2:0] src, input logic [7:0] div);
    clkOutOn = (div != 8'h00) && (src != scb_pkg::CO_SRC_NONE)
               && (src != 3'h2) && (src != 3'h5) && (src != 3'h6);
  endfunction

  logic                    wrEn;
  logic                    rdEn;
  logic [31:0]             wdata;
  logic [7:0]              fracNum_reg;
  logic [7:0]              fracDenom_reg;
  logic                    denomOk_reg;
  logic [1:0]              fracSrc_reg;
  logic [2:0]              coSrc_reg;
  logic [2:0]              coSrc_next;
  logic [7:0]              coDiv_reg;
  logic [7:0]              coDiv_next;
  logic                    coActive_reg;
  logic [31:0]             pinMeta_reg;
  logic [31:0]             pinSync_reg;
  logic [31:0]             pinCapture_reg;
  logic [1:0]              capCnt_reg;
  logic                    capDone_reg;
  logic [1:0]              bodMeta_reg;
  logic [1:0]              bodSync_reg;
  logic [1:0]              bodPrev_reg;
  logic [1:0]              brownout_reset_level_reg;
  logic [1:0]              bodIrqLev_reg;
  logic                    bodRstEn_reg;
  logic [25:0]             tickCal_reg;
  logic [7:0]              irqLat_reg;
  logic [4:0]              nmiNum_reg;
  logic                    nonmaskable_source_enable_reg;
  logic [1:0]              status_reg;
  logic [1:0]              mask_reg;
  logic [1:0]              events;
  logic [31:0]             rdata_reg;
  logic [31:0]             rdata_next;
  scb_pkg::scb_lat_state_t latState_reg;
  scb_pkg::scb_lat_state_t latState_next;
  logic [7:0]              latCnt_reg;
  logic                    grant_reg;
  logic                    nmi_reg;
  logic [31:0]             normal_reg;
  logic                    bodIrq_reg;
  logic                    bodRst_reg;
  logic                    wake_reg;
  logic                    intr_reg;

  assign wrEn  = busReq.wr;
  assign rdEn  = busReq.rd;
  assign wdata = busReq.wdata;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fracNum_reg <= scb_pkg::RST_FRAC_NUM;
    end else if (wrEn && hit(busReq.addr, scb_pkg::OFF_FRAC_NUM)) begin
      fracNum_reg <= wdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fracDenom_reg <= scb_pkg::RST_FRAC_DENOM;
      denomOk_reg   <= 1'b0;
    end else if (wrEn && hit(busReq.addr, scb_pkg::OFF_FRAC_DENOM)) begin
      fracDenom_reg <= wdata[7:0];
      denomOk_reg   <= (wdata[7:0] == scb_pkg::FRAC_DENOM_ONLY);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fracSrc_reg <= scb_pkg::RST_FRAC_SRC;
    end else if (wrEn && hit(busReq.addr, scb_pkg::OFF_FRAC_SRC)) begin
      fracSrc_reg <= wdata[1:0];
    end
  end

  // Reserved source or an unsupported denominator leaves the generator stopped
  assign fracCfg.numerator = fracNum_reg;
  assign fracCfg.src       = fracSrc_reg;
  assign fracCfg.denomOk   = denomOk_reg;

  always_comb begin
    coSrc_next = coSrc_reg;
    coDiv_next = coDiv_reg;
    if (wrEn && hit(busReq.addr, scb_pkg::OFF_CO_SRC)) begin
      coSrc_next = wdata[2:0];
    end
    if (wrEn && hit(busReq.addr, scb_pkg::OFF_CO_DIV)) begin
      coDiv_next = wdata[7:0];
    end
  end

  // source and divider of the clock output pin
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      coSrc_reg    <= scb_pkg::RST_CO_SRC;
      coDiv_reg    <= scb_pkg::RST_CO_DIV;
      coActive_reg <= 1'b0;
    end else begin
      coSrc_reg    <= coSrc_next;
      coDiv_reg    <= coDiv_next;
      coActive_reg <= clkOutOn(coSrc_next, coDiv_next);
    end
  end

  assign clkOutCfg.src    = coSrc_reg;
  assign clkOutCfg.div    = coDiv_reg;
  assign clkOutCfg.active = coActive_reg;

  // Two-stage synchronisers for pins and comparators
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pinMeta_reg <= 32'h00000000;
      pinSync_reg <= 32'h00000000;
      bodMeta_reg <= 2'h0;
      bodSync_reg <= 2'h0;
      bodPrev_reg <= 2'h0;
    end else begin
      pinMeta_reg <= portPinLevels;
      pinSync_reg <= pinMeta_reg;
      bodMeta_reg <= {brownoutRstCross, brownoutIrqCross};
      bodSync_reg <= bodMeta_reg;
      bodPrev_reg <= bodSync_reg;
    end
  end

  // capture once, after the synchronisers have filled
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      capCnt_reg     <= 2'h0;
      capDone_reg    <= 1'b0;
      pinCapture_reg <= 32'h00000000;
    end else if (!capDone_reg) begin
      if (capCnt_reg == scb_pkg::CAPTURE_DELAY) begin
        pinCapture_reg <= pinSync_reg & scb_pkg::PIN_VALID_MASK;
        capDone_reg    <= 1'b1;
      end else begin
        capCnt_reg <= capCnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      brownout_reset_level_reg <= scb_pkg::RST_BOD_LEV;
      bodIrqLev_reg <= scb_pkg::RST_BOD_LEV;
      bodRstEn_reg  <= scb_pkg::RST_BOD_RST_EN;
    end else if (wrEn && hit(busReq.addr, scb_pkg::OFF_BOD_CTRL)) begin
      brownout_reset_level_reg <= wdata[scb_pkg::BOD_RST_LEV_LSB +: 2];
      bodIrqLev_reg <= wdata[scb_pkg::BOD_IRQ_LEV_LSB +: 2];
      bodRstEn_reg  <= wdata[scb_pkg::BOD_RST_EN_BIT];
    end
  end

  assign bodCfg.rstLevel  = brownout_reset_level_reg;
  assign bodCfg.irqLevel  = bodIrqLev_reg;
  assign bodCfg.rstEnable = bodRstEn_reg;

  // reserved level code raises no brownoutIrq; the status event still sets
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bodIrq_reg <= 1'b0;
      bodRst_reg <= 1'b0;
      wake_reg   <= 1'b0;
    end else begin
      bodIrq_reg <= bodSync_reg[0] && (bodIrqLev_reg != scb_pkg::BOD_IRQ_RSVD);
      bodRst_reg <= bodSync_reg[1] && bodRstEn_reg;
      wake_reg   <= (bodSync_reg[0] && (bodIrqLev_reg != scb_pkg::BOD_IRQ_RSVD))
                    || (bodSync_reg[1] && bodRstEn_reg);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tickCal_reg <= scb_pkg::RST_TICK_CAL;
      irqLat_reg  <= scb_pkg::RST_IRQ_LAT;
    end else begin
      if (wrEn && hit(busReq.addr, scb_pkg::OFF_TICK_CAL)) begin
        tickCal_reg <= wdata[25:0];
      end
      if (wrEn && hit(busReq.addr, scb_pkg::OFF_IRQ_LAT)) begin
        irqLat_reg <= wdata[7:0];
      end
    end
  end

  assign tickCalibration = tickCal_reg;
  assign interrupt_latency      = irqLat_reg;

  // hold off service until the latency count has elapsed
  always_comb begin
    case (latState_reg)
      scb_pkg::LAT_IDLE: begin
        if (!irqPending) begin
          latState_next = scb_pkg::LAT_IDLE;
        end else if (irqLat_reg == 8'h00) begin
          latState_next = scb_pkg::LAT_GRANT;
        end else begin
          latState_next = scb_pkg::LAT_WAIT;
        end
      end
      scb_pkg::LAT_WAIT: begin
        if (!irqPending) begin
          latState_next = scb_pkg::LAT_IDLE;
        end else if ({1'b0, latCnt_reg} + 9'h001 >= {1'b0, irqLat_reg}) begin
          latState_next = scb_pkg::LAT_GRANT;
        end else begin
          latState_next = scb_pkg::LAT_WAIT;
        end
      end
      scb_pkg::LAT_GRANT: begin
        latState_next = irqPending ? scb_pkg::LAT_GRANT : scb_pkg::LAT_IDLE;
      end
      default: begin
        latState_next = scb_pkg::LAT_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      latState_reg <= scb_pkg::LAT_IDLE;
      latCnt_reg   <= 8'h00;
      grant_reg    <= 1'b0;
    end else begin
      latState_reg <= latState_next;
      latCnt_reg   <= (latState_reg == scb_pkg::LAT_WAIT) ? latCnt_reg + 8'h01 : 8'h00;
      grant_reg    <= (latState_next == scb_pkg::LAT_GRANT);
    end
  end

  // number and enable of the non-maskable route
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      nmiNum_reg <= scb_pkg::RST_NMI_NUM;
      nonmaskable_source_enable_reg  <= 1'b0;
    end else if (wrEn && hit(busReq.addr, scb_pkg::OFF_NMI_SRC)) begin
      nmiNum_reg <= wdata[4:0];
      nonmaskable_source_enable_reg  <= wdata[scb_pkg::NMI_EN_BIT];
    end
  end

  // the normal path is not suppressed while routed as non-maskable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      nmi_reg    <= 1'b0;
      normal_reg <= 32'h00000000;
    end else begin
      nmi_reg    <= nonmaskable_source_enable_reg && periphIrq[nmiNum_reg];
      normal_reg <= periphIrq;
    end
  end

  // Sticky events; a set in the clearing cycle wins
  assign events = {bodSync_reg[1] && !bodPrev_reg[1], bodSync_reg[0] && !bodPrev_reg[0]};

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      status_reg <= 2'h0;
      mask_reg   <= 2'h0;
      intr_reg   <= 1'b0;
    end else begin
      if (wrEn && hit(busReq.addr, scb_pkg::OFF_IRQ_STATUS)) begin
        status_reg <= (status_reg & ~wdata[1:0]) | events;
      end else begin
        status_reg <= status_reg | events;
      end
      if (wrEn && hit(busReq.addr, scb_pkg::OFF_IRQ_MASK)) begin
        mask_reg <= wdata[1:0];
      end
      intr_reg <= |(status_reg & mask_reg);
    end
  end

  // reserved and unmapped bits read zero
  always_comb begin
    rdata_next = 32'h00000000;
    case (1'b1)
      hit(busReq.addr, scb_pkg::OFF_FRAC_DENOM):  rdata_next[7:0] = fracDenom_reg;
      hit(busReq.addr, scb_pkg::OFF_FRAC_NUM):    rdata_next[7:0] = fracNum_reg;
      hit(busReq.addr, scb_pkg::OFF_FRAC_SRC):    rdata_next[1:0] = fracSrc_reg;
      hit(busReq.addr, scb_pkg::OFF_CO_SRC):      rdata_next[2:0] = coSrc_reg;
      hit(busReq.addr, scb_pkg::OFF_CO_DIV):      rdata_next[7:0] = coDiv_reg;
      hit(busReq.addr, scb_pkg::OFF_PIN_CAPTURE): rdata_next = pinCapture_reg;
      hit(busReq.addr, scb_pkg::OFF_BOD_CTRL):
        rdata_next[4:0] = {bodRstEn_reg, bodIrqLev_reg, brownout_reset_level_reg};
      hit(busReq.addr, scb_pkg::OFF_TICK_CAL):    rdata_next[25:0] = tickCal_reg;
      hit(busReq.addr, scb_pkg::OFF_IRQ_LAT):     rdata_next[7:0] = irqLat_reg;
      hit(busReq.addr, scb_pkg::OFF_NMI_SRC): begin
        rdata_next[4:0]                 = nmiNum_reg;
        rdata_next[scb_pkg::NMI_EN_BIT] = nonmaskable_source_enable_reg;
      end
      hit(busReq.addr, scb_pkg::OFF_IRQ_STATUS):  rdata_next[1:0] = status_reg;
      hit(busReq.addr, scb_pkg::OFF_IRQ_MASK):    rdata_next[1:0] = mask_reg;
      default:                                    rdata_next = 32'h00000000;
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdEn ? rdata_next : 32'h00000000;
    end
  end

  assign busRdata         = rdata_reg;
  assign irqServiceGrant  = grant_reg;
  assign nmiRequest       = nmi_reg;
  assign normalIrq        = normal_reg;
  assign brownoutIrq      = bodIrq_reg;
  assign brownoutResetReq = bodRst_reg;
  assign wakeRequest      = wake_reg;
  assign intr             = intr_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence numWrite_s;
    wrEn && hit(busReq.addr, scb_pkg::OFF_FRAC_NUM);
  endsequence

  sequence numRead_s;
    rdEn && hit(busReq.addr, scb_pkg::OFF_FRAC_NUM);
  endsequence

  numerator_write_a: assert property (
    numWrite_s ##1 numRead_s |=> busRdata == {24'h000000, $past(wdata[7:0], 2)})
    else $error("numerator not read back as written");

  denom_flag_a: assert property (
    wrEn && hit(busReq.addr, scb_pkg::OFF_FRAC_DENOM) |=>
      fracCfg.denomOk == ($past(wdata[7:0]) == scb_pkg::FRAC_DENOM_ONLY))
    else $error("denominator flag wrong after write");

  frac_src_a: assert property (
    wrEn && hit(busReq.addr, scb_pkg::OFF_FRAC_SRC) |=> fracCfg.src == $past(wdata[1:0]))
    else $error("fractional source not updated");

  clock_output_pin_none_a: assert property (
    clkOutCfg.src == scb_pkg::CO_SRC_NONE |-> !clkOutCfg.active)
    else $error("clock output active with no source");

  clock_output_pin_off_a: assert property (
    wrEn && hit(busReq.addr, scb_pkg::OFF_CO_DIV) && wdata[7:0] == 8'h00 |=> !clkOutCfg.active)
    else $error("zero divider left clock output on");

  capture_hold_a: assert property (
    capDone_reg |=> $stable(pinCapture_reg) && !pinCapture_reg[6] && !pinCapture_reg[31])
    else $error("power-on capture changed or holds invalid pins");

  bod_reserved_a: assert property (
    brownoutIrq |-> $past(bodIrqLev_reg) != scb_pkg::BOD_IRQ_RSVD)
    else $error("brown-out irq with reserved level");

  bod_enable_reset_a: assert property (
    $past(!rstn) |-> bodCfg.rstEnable)
    else $error("brown-out reset enable not set at reset");

  bod_wake_a: assert property (
    brownoutIrq || brownoutResetReq |-> wakeRequest)
    else $error("brown-out event without wake-up");

  latency_wait_a: assert property (
    $rose(irqServiceGrant) |-> (interrupt_latency == 8'h00)
      || ({1'b0, $past(latCnt_reg)} + 9'h001 >= {1'b0, interrupt_latency}))
    else $error("interrupt granted before latency elapsed");

  nmi_route_a: assert property (
    ##1 nmiRequest == $past(nonmaskable_source_enable_reg && periphIrq[nmiNum_reg]))
    else $error("non-maskable route wrong");

  nmi_both_a: assert property (
    nmiRequest |-> normalIrq[$past(nmiNum_reg)])
    else $error("normal request missing beside non-maskable");

  reserved_zero_a: assert property (
    rdEn && hit(busReq.addr, scb_pkg::OFF_IRQ_LAT) |=> busRdata[31:8] == 24'h000000)
    else $error("reserved latency bits not zero");

  sticky_irq_a: assert property (
    |(status_reg & mask_reg) |=> intr)
    else $error("unmasked status did not raise interrupt");

endmodule

// ---- verification/scb_core_model.sv ----
module scb_core_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Bench side
  input  wire logic [31:0] raiseIrq,
  input  wire logic        wantService,
  // Device side
  input  wire logic        irqServiceGrant,
  output logic [31:0]      periphIrq,
  output logic             irqPending
);
  timeunit 1ns;
  timeprecision 1ns;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      periphIrq <= '0;
    end else begin
      periphIrq <= raiseIrq;
    end
  end

  // service after grant
  // Pending holds until the grant shows; the core then takes it and lets go
  always_ff @(posedge core_clk) begin
    if (!rstn || irqServiceGrant) begin
      irqPending <= 1'b0;
    end else if (wantService) begin
      irqPending <= 1'b1;
    end
  end
endmodule

// ---- verification/sysconfig_clock_bod_nmi_regs_bench.sv ----
module sysconfig_clock_bod_nmi_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, irqPending, wantService, grant;
  logic brIrqX, brRstX, irqOut;
  scb_pkg::scb_bus_t busReq;
  logic [31:0] busRdata, pins, periphIrq, raiseIrq, normalIrq;
  scb_pkg::scb_frac_t fracCfg;
  scb_pkg::scb_clock_output_pin_t coCfg;
  scb_pkg::scb_bod_t bodCfg;
  logic [25:0] tickCal;
  logic [7:0] lat;
  logic nmi, brIrq, brRst, wake;
  int nFail, checksDone, cycles, n;
  logic [31:0] rAddr [9] = '{scb_pkg::OFF_FRAC_DENOM, scb_pkg::OFF_FRAC_NUM,
    scb_pkg::OFF_FRAC_SRC, scb_pkg::OFF_CO_SRC, scb_pkg::OFF_CO_DIV, scb_pkg::OFF_BOD_CTRL,
    scb_pkg::OFF_TICK_CAL, scb_pkg::OFF_IRQ_LAT, scb_pkg::OFF_NMI_SRC};
  logic [31:0] rRst [9] = '{0, 0, 0, 0, 0, 32'h10, 0, 32'h10, 0};
  logic [31:0] rMax [9] = '{32'hff, 32'hff, 32'h3, 32'h7, 32'hff, 32'h1f, 32'h3ffffff,
    32'hff, 32'h8000001f};

  scb_sysconfig_regs u_dut (.core_clk(core_clk), .rstn(rstn), .busReq(busReq),
    .busRdata(busRdata), .portPinLevels(pins), .brownoutIrqCross(brIrqX),
    .brownoutRstCross(brRstX), .periphIrq(periphIrq), .irqPending(irqPending),
    .fracCfg(fracCfg), .clkOutCfg(coCfg), .bodCfg(bodCfg), .tickCalibration(tickCal),
    .interrupt_latency(lat), .irqServiceGrant(grant), .nmiRequest(nmi), .normalIrq(normalIrq),
    .brownoutIrq(brIrq), .brownoutResetReq(brRst), .wakeRequest(wake), .intr(irqOut));
  scb_core_model u_core (.core_clk(core_clk), .rstn(rstn), .raiseIrq(raiseIrq),
    .wantService(wantService), .irqServiceGrant(grant), .periphIrq(periphIrq),
    .irqPending(irqPending));

  always #10 core_clk = ~core_clk;

  task automatic summarize();
    if (nFail == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Long enough for every scenario with ample margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      nFail++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge core_clk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] e);
    @(posedge core_clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 chk(what, e, busRdata);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  initial begin
    core_clk = 0;
    rstn = 0;
    busReq = '0;
    pins = 32'hffffffff;
    brIrqX = 0;
    brRstX = 0;
    raiseIrq = '0;
    wantService = 0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    settle(6);
    pins <= '0;
    chk("rstEnable", 1, bodCfg.rstEnable);
    for (int i = 0; i < 9; i++) rchk("reset value", rAddr[i], rRst[i]);
    for (int i = 0; i < 9; i++) wr(rAddr[i], 32'hffffffff);
    for (int i = 0; i < 9; i++) rchk("reserved bits", rAddr[i], rMax[i]);
    chk("numerator", 8'hff, fracCfg.numerator);
    chk("fracSrc", 2'h3, fracCfg.src);
    chk("denomOk", 1, fracCfg.denomOk);
    chk("calibration", 26'h3ffffff, tickCal);
    chk("latency", 8'hff, lat);
    // Write then read with no gap between the strobes
    @(posedge core_clk);
    busReq <= '{addr: scb_pkg::OFF_FRAC_NUM, wdata: 32'h5a, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    busReq <= '{addr: scb_pkg::OFF_FRAC_NUM, wdata: 32'h5a, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 chk("numerator", 32'h5a, busRdata);
    wr(scb_pkg::OFF_FRAC_DENOM, 32'hfe);
    settle(1);
    chk("denomOk", 0, fracCfg.denomOk);
    // Pins were high through reset, then dropped: capture must not follow
    wr(scb_pkg::OFF_PIN_CAPTURE, 0);
    rchk("capture", scb_pkg::OFF_PIN_CAPTURE, 32'h7fffffbf);
    rchk("unmapped", 32'h400480dc, 0);
    wr(scb_pkg::OFF_CO_DIV, 3);
    for (int s = 0; s < 8; s++) begin
      wr(scb_pkg::OFF_CO_SRC, s);
      settle(1);
      chk("coActive", s inside {0, 1, 3, 4}, coCfg.active);
    end
    wr(scb_pkg::OFF_CO_SRC, 1);
    wr(scb_pkg::OFF_CO_DIV, 0);
    settle(1);
    chk("coOff", 0, coCfg.active);
    chk("coSrc", 1, coCfg.src);
    chk("coDiv", 0, coCfg.div);
    // Brown-out: interrupt level 1, reset disabled
    wr(scb_pkg::OFF_BOD_CTRL, 32'h04);
    wr(scb_pkg::OFF_IRQ_MASK, 3);
    brIrqX <= 1'b1;
    brRstX <= 1'b1;
    settle(6);
    chk("bodIrq", 1, brIrq);
    chk("irqLevel", 1, bodCfg.irqLevel);
    chk("bodRst", 0, brRst);
    chk("wake", 1, wake);
    chk("intr", 1, irqOut);
    rchk("status", scb_pkg::OFF_IRQ_STATUS, 3);
    brIrqX <= 1'b0;
    brRstX <= 1'b0;
    wr(scb_pkg::OFF_IRQ_STATUS, 1);
    rchk("status", scb_pkg::OFF_IRQ_STATUS, 2);
    wr(scb_pkg::OFF_IRQ_MASK, 1);
    settle(3);
    chk("intrMasked", 0, irqOut);
    wr(scb_pkg::OFF_IRQ_STATUS, 2);
    rchk("status", scb_pkg::OFF_IRQ_STATUS, 0);
    // Reserved interrupt level, reset enabled
    wr(scb_pkg::OFF_BOD_CTRL, 32'h10);
    brIrqX <= 1'b1;
    brRstX <= 1'b1;
    settle(6);
    chk("bodIrq", 0, brIrq);
    chk("bodRst", 1, brRst);
    chk("wake", 1, wake);
    chk("rstLevel", 0, bodCfg.rstLevel);
    brIrqX <= 1'b0;
    brRstX <= 1'b0;
    foreach (rRst[i]) begin
      if (i == 0 || i == 3) begin
        wr(scb_pkg::OFF_IRQ_LAT, i);
        @(posedge core_clk);
        wantService <= 1'b1;
        n = 0;
        while (irqPending !== 1'b1) settle(1);
        while (grant !== 1'b1 && n < 300) begin
          settle(1);
          n++;
        end
        wantService <= 1'b0;
        chk("grantDelay", i + 1, n);
        settle(4);
      end
    end
    // Disable, change number, enable
    wr(scb_pkg::OFF_NMI_SRC, 0);
    wr(scb_pkg::OFF_NMI_SRC, 5);
    wr(scb_pkg::OFF_NMI_SRC, 32'h80000005);
    raiseIrq <= 32'h20;
    settle(3);
    chk("nmi", 1, nmi);
    chk("normalIrq", 32'h20, normalIrq);
    wr(scb_pkg::OFF_NMI_SRC, 32'h80000006);
    settle(2);
    chk("nmiOther", 0, nmi);
    wr(scb_pkg::OFF_NMI_SRC, 5);
    settle(2);
    chk("nmiOff", 0, nmi);
    summarize();
  end
endmodule
